// ### rtl/gsds_top.sv
// Geometry stage dispatch: state registers over APB and thread header build
`timescale 1ns/1ps
`default_nettype none
module gsds_top
  import gsds_pkg::*;
#(
  parameter int MAX_THREADS = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire logic [31:5] binding_ptr,
  input wire logic vtx_valid,
  input wire gsds_vtx_t vtx_data,
  output var logic vtx_ready,
  output var logic thr_valid,
  input wire logic thr_ready,
  output var gsds_hdr_t thr_hdr,
  input wire logic thr_done,
  input wire logic thr_done_tag,
  output var logic cfg_error
);
  logic [31:0] w1;
  logic [31:0] w2;
  logic [31:0] w3;
  logic [31:0] w4;
  logic [31:0] w5;
  logic [31:0] w6;
  logic [31:0] ctrl;
  logic [23:0] tid;
  logic [1:0] busy;
  logic [31:0] next_prdata;
  gsds_state_t state;
  logic [8:0] sv0;
  logic [8:0] sv1;
  logic [8:0] sv2;
  logic [4:0] stopo;
  logic s_valid;
  logic s_ready;
  logic s_in_ready;

  // Scratch byte offset for a thread slot: slot << (code + 10) expressed in KB units
  function automatic logic [31:10] gsds_scratch(input logic [31:10] base, input logic [3:0] code,
                                                input logic slot);
    logic [21:0] step;
    step = 22'h000001 << code;
    gsds_scratch = slot ? base + step : base;
  endfunction : gsds_scratch

  // Address decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire sel_w1 = paddr == GSDS_OFF_W1;
  wire sel_w2 = paddr == GSDS_OFF_W2;
  wire sel_w3 = paddr == GSDS_OFF_W3;
  wire sel_w4 = paddr == GSDS_OFF_W4;
  wire sel_w5 = paddr == GSDS_OFF_W5;
  wire sel_w6 = paddr == GSDS_OFF_W6;
  wire sel_ctrl = paddr == GSDS_OFF_CTRL;
  wire sel_stat = paddr == GSDS_OFF_STAT;
  wire sel_tid = paddr == GSDS_OFF_TID;
  wire sel_w0 = paddr == GSDS_OFF_W0;
  wire mapped = sel_w0 | sel_w1 | sel_w2 | sel_w3 | sel_w4 | sel_w5 | sel_w6 | sel_ctrl | sel_stat | sel_tid;

  // Decoded state fields
  wire enabled = ctrl[GSDS_CTRL_EN];
  wire two_thr = w4[GSDS_MAXT_LO +: 5] == 5'h01;
  wire [6:0] n_ent = w4[GSDS_NENT_LO +: 7];
  wire [3:0] scr_code = w2[3:0];
  wire [2:0] smp_cnt = w5[2:0];
  // Illegal settings flagged on cfg_error and block any launch
  wire bad_cfg = !w1[GSDS_SPF_BIT]
    || (w4[GSDS_MAXT_LO +: 5] > 5'h01)
    || (scr_code > GSDS_SCR_MAX)
    || (smp_cnt > GSDS_SMP_MAX)
    || (enabled && (n_ent == 7'h00 || n_ent > GSDS_NENT_MAX))
    || (two_thr && n_ent[0])
    || (w3[GSDS_VRL_LO +: 6] == 6'h00);
  wire [6:0] half = two_thr ? {1'b0, n_ent[6:1]} : n_ent;
  // A one-thread build never opens the second slot
  wire [1:0] limit = (two_thr && MAX_THREADS > 1) ? 2'b11 : 2'b01;
  // Free slot choice: lowest tag not busy within limit
  wire slot0_free = !busy[0];
  wire slot1_free = !busy[1] && limit[1];
  wire have_slot = slot0_free || slot1_free;
  wire pick = !slot0_free;
  wire launch = enabled && !bad_cfg && s_valid && have_slot && state == GSDS_IDLE;
  assign s_ready = launch;

  gsds_staging u_stage (
    .pclk(pclk),
    .presetn(presetn),
    .reorder(w6[GSDS_REORD_BIT]),
    .in_valid(vtx_valid && vtx_ready && enabled),
    .in_vtx(vtx_data),
    .in_ready(s_in_ready),
    .obj_valid(s_valid),
    .obj_ready(s_ready),
    .obj_v0(sv0),
    .obj_v1(sv1),
    .obj_v2(sv2),
    .obj_topo(stopo)
  );

  // Read mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (sel_w1) next_prdata = w1;
    if (sel_w2) next_prdata = w2;
    if (sel_w3) next_prdata = w3;
    if (sel_w4) next_prdata = w4;
    if (sel_w5) next_prdata = w5;
    if (sel_w6) next_prdata = w6;
    if (sel_ctrl) next_prdata = ctrl;
    if (sel_stat) next_prdata = {27'h0, bad_cfg, busy, state};
    if (sel_tid) next_prdata = {8'h00, tid};
  end

  // APB slave: one wait-free access phase, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= GSDS_RESET;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= next_prdata;
    end
  end

  // State word writes; only writable fields stored, MBZ bits dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w1 <= 32'h8000_0000;
      w2 <= GSDS_RESET;
      w3 <= 32'h0000_0800;
      w4 <= 32'h0000_0800;
      w5 <= GSDS_RESET;
      w6 <= GSDS_RESET;
      ctrl <= GSDS_RESET;
    end else if (wr && pready && mapped) begin
      if (sel_w1) w1 <= pwdata & 32'h83fd_2880;
      if (sel_w2) w2 <= pwdata & 32'hffff_fc0f;
      if (sel_w3) w3 <= pwdata & 32'h7efd_f800;
      if (sel_w4) w4 <= pwdata & 32'h3ef9_f800;
      if (sel_w5) w5 <= pwdata & 32'hffff_ffe7;
      if (sel_w6) w6 <= pwdata & 32'h4000_0000;
      if (sel_ctrl) ctrl <= pwdata & 32'h0000_0003;
    end
  end

  // Ready only while staging holds no object, so a vertex taken at the pin is never dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vtx_ready <= 1'b0;
      cfg_error <= 1'b0;
    end else begin
      vtx_ready <= s_in_ready && enabled && !s_valid && !(vtx_valid && vtx_ready);
      cfg_error <= bad_cfg;
    end
  end

  // Thread slots: set on launch wins over completion clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (launch && pick == 1'(i)) busy[i] <= 1'b1;
        else if (thr_done && thr_done_tag == 1'(i)) busy[i] <= 1'b0;
      end
    end
  end

  // Dispatch: header built at launch and held until taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= GSDS_IDLE;
      thr_valid <= 1'b0;
      thr_hdr <= '0;
      tid <= 24'h000000;
    end else begin
      case (state)
        GSDS_IDLE: begin
          if (launch) begin
            thr_valid <= 1'b1;
            state <= GSDS_SEND;
            tid <= tid + 24'h000001;
            thr_hdr.thread_id <= tid;
            thr_hdr.snapshot <= ctrl[GSDS_CTRL_DBG];
            thr_hdr.scratch <= gsds_scratch(w2[31:10], scr_code, pick);
            thr_hdr.tag <= pick;
            thr_hdr.sampler_ptr <= w5[31:5];
            thr_hdr.binding_ptr <= binding_ptr;
            thr_hdr.topo <= stopo;
            thr_hdr.exc_cr[GSDS_CR_ILL] <= w1[GSDS_EX_ILL_BIT];
            thr_hdr.exc_cr[GSDS_CR_MSK] <= w1[GSDS_EX_MSK_BIT];
            thr_hdr.exc_cr[GSDS_CR_SW] <= w1[GSDS_EX_SW_BIT];
            thr_hdr.fp_mode <= w1[GSDS_FPM_BIT];
            thr_hdr.single_flow <= w1[GSDS_SPF_BIT];
            thr_hdr.crd_off <= w3[GSDS_CRO_LO +: 6];
            thr_hdr.crd_len <= w3[GSDS_CRL_LO +: 6];
            thr_hdr.vrd_len <= w3[GSDS_VRL_LO +: 6];
            thr_hdr.bt_count <= w1[GSDS_BTC_LO +: 8];
            thr_hdr.smp_count <= smp_cnt;
            // Each thread owns half the entries in two-thread mode
            thr_hdr.entry_base <= pick ? half : 7'h00;
            thr_hdr.v0 <= sv0;
            thr_hdr.v1 <= sv1;
            thr_hdr.v2 <= sv2;
          end
        end
        GSDS_SEND: begin
          if (thr_ready) begin
            thr_valid <= 1'b0;
            state <= GSDS_WAIT;
          end
        end
        GSDS_WAIT: begin
          state <= GSDS_IDLE;
        end
        default: begin
          state <= GSDS_IDLE;
          thr_valid <= 1'b0;
        end
      endcase
    end
  end
endmodule : gsds_top
`default_nettype wire

// ### rtl/gsds_pkg.sv
// Package for the geometry stage dispatch block: state fields, payload layout, types
package gsds_pkg;
  localparam int GSDS_ADDR_W = 12;
  // Register byte offsets (state words, control, status and thread id, one aligned word each)
  localparam logic [11:0] GSDS_OFF_W0 = 12'h000;
  localparam logic [11:0] GSDS_OFF_W1 = 12'h004;
  localparam logic [11:0] GSDS_OFF_W2 = 12'h008;
  localparam logic [11:0] GSDS_OFF_W3 = 12'h00c;
  localparam logic [11:0] GSDS_OFF_W4 = 12'h010;
  localparam logic [11:0] GSDS_OFF_W5 = 12'h014;
  localparam logic [11:0] GSDS_OFF_W6 = 12'h018;
  localparam logic [11:0] GSDS_OFF_CTRL = 12'h020;
  localparam logic [11:0] GSDS_OFF_STAT = 12'h024;
  localparam logic [11:0] GSDS_OFF_TID = 12'h028;
  // Word one fields
  localparam int GSDS_SPF_BIT = 31;
  localparam int GSDS_BTC_LO = 18;
  localparam int GSDS_FPM_BIT = 16;
  localparam int GSDS_EX_ILL_BIT = 13;
  localparam int GSDS_EX_MSK_BIT = 11;
  localparam int GSDS_EX_SW_BIT = 7;
  // Thread control bit positions for exception enables
  localparam int GSDS_CR_ILL = 12;
  localparam int GSDS_CR_MSK = 11;
  localparam int GSDS_CR_SW = 13;
  // Word two, three, four, five, six fields
  localparam int GSDS_SCR_LO = 10;
  localparam int GSDS_CRL_LO = 25;
  localparam int GSDS_CRO_LO = 18;
  localparam int GSDS_VRL_LO = 11;
  localparam int GSDS_MAXT_LO = 25;
  localparam int GSDS_ESZ_LO = 19;
  localparam int GSDS_NENT_LO = 11;
  localparam int GSDS_SMP_LO = 5;
  localparam int GSDS_REORD_BIT = 30;
  localparam logic [3:0] GSDS_SCR_MAX = 4'hb;
  localparam logic [2:0] GSDS_SMP_MAX = 3'h4;
  localparam logic [6:0] GSDS_NENT_MAX = 7'h20;
  // Control register bits
  localparam int GSDS_CTRL_EN = 0;
  localparam int GSDS_CTRL_DBG = 1;
  // Topology codes
  localparam logic [4:0] GSDS_TOPO_TRISTRIP = 5'h05;
  localparam logic [4:0] GSDS_TOPO_REVERSED_TRIANGLE_STRIP = 5'h12;
  localparam logic [4:0] GSDS_TOPO_TRILIST = 5'h04;
  localparam logic [31:0] GSDS_RESET = 32'h0000_0000;

  // Incoming vertex from the upstream stage
  typedef struct packed {
    logic [8:0] handle;
    logic [4:0] topo;
    logic start;
    logic last;
  } gsds_vtx_t;

  // Header handed to the execution unit with the thread
  typedef struct packed {
    logic snapshot;
    logic [23:0] thread_id;
    logic [31:10] scratch;
    logic tag;
    logic [31:5] sampler_ptr;
    logic [31:5] binding_ptr;
    logic [4:0] topo;
    logic [13:11] exc_cr;
    logic fp_mode;
    logic single_flow;
    logic [5:0] crd_off;
    logic [5:0] crd_len;
    logic [5:0] vrd_len;
    logic [7:0] bt_count;
    logic [2:0] smp_count;
    logic [6:0] entry_base;
    logic [8:0] v0;
    logic [8:0] v1;
    logic [8:0] v2;
  } gsds_hdr_t;

  typedef enum logic [1:0] {
    GSDS_IDLE = 2'b00,
    GSDS_SEND = 2'b01,
    GSDS_WAIT = 2'b10
  } gsds_state_t;
endpackage : gsds_pkg

// ### rtl/gsds_staging.sv
// Object staging buffer: collects triangle strip vertices into objects
`timescale 1ns/1ps
`default_nettype none
module gsds_staging
  import gsds_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reorder,
  input wire logic in_valid,
  input wire gsds_vtx_t in_vtx,
  output logic in_ready,
  output var logic obj_valid,
  input wire logic obj_ready,
  output var logic [8:0] obj_v0,
  output var logic [8:0] obj_v1,
  output var logic [8:0] obj_v2,
  output var logic [4:0] obj_topo
);
  logic [8:0] hist0;
  logic [8:0] hist1;
  logic [1:0] count;
  logic odd;
  wire take = in_valid && in_ready;
  wire strip = (in_vtx.topo == GSDS_TOPO_TRISTRIP);
  wire full_obj = (count == 2'd2) || (!strip && count == 2'd2);
  wire odd_now = strip && odd;

  // Stall intake while a finished object waits for the dispatcher
  assign in_ready = !obj_valid || obj_ready;

  // Sliding window over the strip, one object per completed triangle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist0 <= 9'h000;
      hist1 <= 9'h000;
      count <= 2'd0;
      odd <= 1'b0;
      obj_valid <= 1'b0;
      obj_v0 <= 9'h000;
      obj_v1 <= 9'h000;
      obj_v2 <= 9'h000;
      obj_topo <= 5'h00;
    end else begin
      if (obj_valid && obj_ready) begin
        obj_valid <= 1'b0;
      end
      if (take) begin
        if (in_vtx.start) begin
          hist0 <= in_vtx.handle;
          count <= 2'd1;
          odd <= 1'b0;
        end else if (count == 2'd1) begin
          hist1 <= in_vtx.handle;
          count <= 2'd2;
        end else if (full_obj) begin
          obj_valid <= 1'b1;
          if (odd_now && reorder) begin
            obj_v0 <= hist1;
            obj_v1 <= hist0;
          end else begin
            obj_v0 <= hist0;
            obj_v1 <= hist1;
          end
          obj_v2 <= in_vtx.handle;
          // Strip topology alternates even with reorder off
          obj_topo <= odd_now ? GSDS_TOPO_REVERSED_TRIANGLE_STRIP : in_vtx.topo;
          if (strip) begin
            hist0 <= hist1;
            hist1 <= in_vtx.handle;
            odd <= !odd;
          end else begin
            count <= 2'd0;
          end
        end else begin
          hist0 <= in_vtx.handle;
          count <= 2'd1;
        end
      end
    end
  end
endmodule : gsds_staging
`default_nettype wire

// ### test/gsds_top_assertions.sv
// Port-level checks for the geometry stage dispatch block
`timescale 1ns/1ps
`default_nettype none
module gsds_top_assertions
  import gsds_pkg::*;
#(
  parameter int MAX_THREADS = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic vtx_valid,
  input wire logic vtx_ready,
  input wire logic thr_valid,
  input wire logic thr_ready,
  input wire gsds_hdr_t thr_hdr,
  input wire logic cfg_error
);
  logic [31:0] w1, w2, w4, w5;
  logic [23:0] last_id;
  logic seen;
  wire logic wr_ok = psel && penable && pready && pwrite && !pslverr;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow state words; a rewrite while a thread waits is not modelled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w1 <= 32'h8000_0000;
      w2 <= 32'h0000_0000;
      w4 <= 32'h0000_0800;
      w5 <= 32'h0000_0000;
      last_id <= 24'h00_0000;
      seen <= 1'b0;
    end else begin
      if (wr_ok && paddr == GSDS_OFF_W1) w1 <= pwdata;
      if (wr_ok && paddr == GSDS_OFF_W2) w2 <= pwdata;
      if (wr_ok && paddr == GSDS_OFF_W4) w4 <= pwdata;
      if (wr_ok && paddr == GSDS_OFF_W5) w5 <= pwdata;
      if (thr_valid && thr_ready) last_id <= thr_hdr.thread_id;
      if (thr_valid && thr_ready) seen <= 1'b1;
    end
  end
  apb_wait_a: assert property (psel && !penable |=> pready)
    else $error("setup not answered in access cycle");
  vtx_gap_a: assert property (vtx_valid && vtx_ready |=> !vtx_ready)
    else $error("vertex ready held after take");
  thr_hold_a: assert property (thr_valid && !thr_ready |=> thr_valid && $stable(thr_hdr))
    else $error("header dropped or changed while waiting");
  mode_copy_a: assert property (thr_valid |-> {thr_hdr.single_flow, thr_hdr.fp_mode, thr_hdr.exc_cr} == {w1[31], w1[16], w1[7], w1[13], w1[11]})
    else $error("mode or exception bits misrouted");
  smp_ptr_a: assert property (thr_valid |-> thr_hdr.sampler_ptr == w5[31:5] && thr_hdr.smp_count == w5[2:0])
    else $error("sampler fields wrong");
  scratch_at_a: assert property (thr_valid |-> thr_hdr.scratch == w2[31:10] + (thr_hdr.tag ? 22'h1 << w2[3:0] : 22'h0))
    else $error("scratch slice wrong");
  entry_half_a: assert property (thr_valid |-> thr_hdr.entry_base == (thr_hdr.tag ? {1'b0, w4[17:12]} : 7'h00))
    else $error("entry base not half");
  cfg_bad_a: assert property (w4[29:25] > 5'h01 |-> ##[0:2] cfg_error)
    else $error("illegal thread count accepted");
  tid_fresh_a: assert property (thr_valid && seen |-> thr_hdr.thread_id != last_id)
    else $error("thread id repeated");
endmodule : gsds_top_assertions
bind gsds_top gsds_top_assertions #(.MAX_THREADS(MAX_THREADS)) chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .vtx_valid, .vtx_ready, .thr_valid, .thr_ready, .thr_hdr, .cfg_error);
`default_nettype wire

// ### test/gsds_eu_model.sv
// Execution unit stand-in: takes thread headers and retires them later
`timescale 1ns/1ps
`default_nettype none
module gsds_eu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic thr_valid,
  input wire logic thr_tag,
  output var logic thr_ready,
  output var logic thr_done,
  output var logic thr_done_tag
);
  logic tags[$];
  int age;
  // Slow mode accepts every other cycle; oldest thread retires after nine busy cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_ready <= 1'b0;
      thr_done <= 1'b0;
      thr_done_tag <= 1'b0;
      tags.delete();
      age = 0;
    end else begin
      thr_ready <= slow ? !thr_ready : 1'b1;
      thr_done <= 1'b0;
      if (thr_valid && thr_ready) tags.push_back(thr_tag);
      age = tags.size() != 0 ? age + 1 : 0;
      if (age > 8) begin
        thr_done <= 1'b1;
        thr_done_tag <= tags.pop_front();
        age = 0;
      end else begin
        thr_done_tag <= !thr_done_tag; // Tag means nothing outside a done pulse
      end
    end
  end
endmodule : gsds_eu_model
`default_nettype wire

// ### test/gsds_top_tb.sv
// Self-checking bench for the geometry stage dispatch block
`timescale 1ns/1ps
`default_nettype none
module gsds_top_tb;
  import gsds_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, vtx_valid = 1'b0, vtx_ready, thr_valid, thr_ready, thr_done, thr_done_tag;
  logic cfg_error, slow = 1'b0, dbg = 1'b0;
  logic [31:5] binding_ptr = 27'h000_0000;
  gsds_vtx_t vtx_data = '0;
  gsds_hdr_t thr_hdr;
  logic [31:0] exq[$];
  int fails = 0, compares = 0, seed = 32'h03b8;
  logic [11:0] ra[4] = '{GSDS_OFF_W1, GSDS_OFF_W2, GSDS_OFF_W3, GSDS_OFF_W4};
  logic [31:0] rv[4] = '{32'h8000_0000, 32'h0000_0000, 32'h0000_0800, 32'h0000_0800};
  logic [11:0] wa[6] = '{GSDS_OFF_W1, GSDS_OFF_W2, GSDS_OFF_W3, GSDS_OFF_W5, GSDS_OFF_W6, GSDS_OFF_CTRL};
  logic [31:0] wd[6] = '{32'h80c1_2800, 32'h0004_0003, 32'h0404_2000, 32'h0000_1242, 32'h4000_0000, 32'h0000_0001};
  logic [31:0] bad[4] = '{32'h0418_4000, 32'h0218_0000, 32'h0218_2800, 32'h0218_4000};
  always #5 pclk = !pclk;
  gsds_top #(.MAX_THREADS(2)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .binding_ptr, .vtx_valid, .vtx_data, .vtx_ready, .thr_valid, .thr_ready, .thr_hdr, .thr_done,
    .thr_done_tag, .cfg_error);
  gsds_eu_model eu (.pclk, .presetn, .slow, .thr_valid, .thr_tag(thr_hdr.tag), .thr_ready, .thr_done,
    .thr_done_tag);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // One APB transfer; read data and error are taken at the pready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && n++ < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge pclk);
  endtask : apb
  task automatic vtx(input logic [8:0] h, input logic [4:0] t, input logic s, input logic l);
    int n;
    n = 0;
    vtx_valid <= 1'b1;
    vtx_data <= '{h, t, s, l};
    do @(posedge pclk); while (vtx_ready !== 1'b1 && n++ < 400);
    vtx_valid <= 1'b0;
    vtx_data <= gsds_vtx_t'($random(seed));
    @(posedge pclk);
  endtask : vtx
  // Sends one topology and notes the objects it should become
  task automatic stream(input int n, input logic [4:0] t, input logic ro);
    logic [8:0] h;
    for (int k = 0; k < n; k++) begin
      h = 9'h040 + 9'(k);
      if (t == GSDS_TOPO_TRISTRIP && k >= 2)
        exq.push_back(k % 2 == 0 ? {h - 9'h2, h - 9'h1, h, t} : ro ? {h - 9'h1, h - 9'h2, h, GSDS_TOPO_REVERSED_TRIANGLE_STRIP}
          : {h - 9'h2, h - 9'h1, h, GSDS_TOPO_REVERSED_TRIANGLE_STRIP});
      else if (t != GSDS_TOPO_TRISTRIP && k % 3 == 2)
        exq.push_back({h - 9'h2, h - 9'h1, h, t});
      vtx(h, t, k == 0, k == n - 1);
    end
  endtask : stream
  // Oldest note against each accepted header; fixed fields follow the programmed words
  always @(posedge pclk) begin
    if (presetn && thr_valid === 1'b1 && thr_ready === 1'b1) begin
      if (exq.size() == 0) chk("extra thread", 32'h0000_0000, 32'h0000_0001);
      else chk("object", exq.pop_front(), {thr_hdr.v0, thr_hdr.v1, thr_hdr.v2, thr_hdr.topo});
      chk("modes", 32'h0000_001b, {27'h0, thr_hdr.single_flow, thr_hdr.fp_mode, thr_hdr.exc_cr});
      chk("scratch", {10'h0, thr_hdr.tag ? 22'h108 : 22'h100}, {10'h0, thr_hdr.scratch});
      chk("sampler", 32'h0000_0092, {5'h0, thr_hdr.sampler_ptr});
      chk("binding", {binding_ptr, 5'h0}, {thr_hdr.binding_ptr, 5'h0});
      chk("reads", {14'h0, 6'h1, 6'h2, 6'h4}, {14'h0, thr_hdr.crd_off, thr_hdr.crd_len, thr_hdr.vrd_len});
      chk("counts", 32'h0000_0182, {21'h0, thr_hdr.bt_count, thr_hdr.smp_count});
      chk("entry base", {25'h0, thr_hdr.tag ? 7'h04 : 7'h00}, {25'h0, thr_hdr.entry_base});
      chk("snapshot", {31'h0, dbg}, {31'h0, thr_hdr.snapshot});
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    $display("test timed out");
    stop_test();
  end
  initial begin
    binding_ptr <= 27'($random(seed));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ra[i], 32'h0000_0000);
      chk("reset value", rv[i], rd);
    end
    apb(1'b0, 12'h01c, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0, err});
    $display("test reset and map done");
    for (int i = 0; i < 6; i++) apb(1'b1, wa[i], wd[i]);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, GSDS_OFF_W4, bad[i]);
      repeat (2) @(posedge pclk);
      chk("config error", {31'h0, i < 3}, {31'h0, cfg_error});
    end
    $display("test config legality done");
    for (int p = 0; p < 2; p++) begin
      dbg = p[0];
      slow <= p[0];
      apb(1'b1, GSDS_OFF_W6, {1'b0, !p[0], 30'h0});
      apb(1'b1, GSDS_OFF_CTRL, {30'h0, p[0], 1'b1});
      stream(5, GSDS_TOPO_TRISTRIP, !p[0]);
      stream(6, GSDS_TOPO_TRILIST, 1'b0);
      for (int n = 0; n < 500 && exq.size() != 0; n++) @(posedge pclk);
      chk("threads left", 32'h0000_0000, exq.size());
      repeat (30) @(posedge pclk);
      $display("test traffic pass %0d done", p);
    end
    stop_test();
  end
endmodule : gsds_top_tb
`default_nettype wire
